// >>> bench/vwd_display_sva.sv
// Purpose: port checks of vwd_display
// Assumes: one clock, sync low reset
// Notes: bound to vwd_display
`timescale 1ns/100ps
module vwd_display_sva
import vwd_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input vwd_timing_s timing,
    input logic rd_valid,
    input logic mem_rvalid,
    input logic mem_rready,
    input logic pix_valid,
    input logic pix_ready,
    input logic [15:0] pix_data
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    resp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    read_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    pix_hold_a:
    assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
        else $error("stalled pixel changed");
    take_to_pix_a:
    assert property (mem_rvalid && mem_rready |=> pix_valid)
        else $error("return not offered");
    fetch_in_de_a:
    assert property (rd_valid |-> $past(timing.de))
        else $error("fetch outside active display");
endmodule
bind vwd_display vwd_display_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .timing, .rd_valid, .mem_rvalid, .mem_rready, .pix_valid, .pix_ready,
    .pix_data);

// >>> bench/vwd_display_tb_top.sv
// Purpose: self-checking bench of vwd_display
// Assumes: 40 MHz clock, 16x4 test raster, window 4x2 at (2,1)
// Notes: rows first, then hand cases
`timescale 1ns/100ps
module vwd_display_tb_top;
import vwd_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic cap_frame_done, rd_valid, mem_rvalid, mem_rready, pix_valid, pix_ready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, rs, lb;
    logic [21:0] rd_addr;
    logic [15:0] mem_rdata, pix_data;
    vwd_timing_s timing;
    logic [21:0] aq[$];
    logic [15:0] pq[$];
    int fails, total_checks, cyc;
    logic [71:0] rows [15] = '{{8'h00, 32'h2, 32'h2}, {8'h00, 32'h0, 32'h0}, {8'h0C, 32'h4, 32'h4},
        {8'h10, 32'h2, 32'h2}, {8'h14, 32'h280, 32'h280}, {8'h18, 32'h1E0, 32'h1E0},
        {8'h1C, 32'hFFFFFFFF, 32'h7FF}, {8'h1C, 32'h2, 32'h2}, {8'h20, 32'h1, 32'h1},
        {8'h24, 32'h100, 32'h100}, {8'h28, 32'h2000, 32'h2000}, {8'h2C, 32'hFFFFFFFF, 32'h3FFFFF},
        {8'h30, 32'hFF, 32'h0}, {8'h34, 32'h5, 32'h0}, {8'h04, 32'h1, 32'h1}};
    vwd_display u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timing, .cap_frame_done,
        .rd_valid, .rd_addr, .mem_rvalid, .mem_rdata, .mem_rready, .pix_valid, .pix_ready, .pix_data);
    vwd_mem_model u_mem (.aclk, .aresetn, .rd_valid, .rd_addr, .mem_rready, .mem_rvalid, .mem_rdata);
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        lb = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic vs(input logic fo);
        timing <= '{1'b0, 1'b0, 1'b1, fo, 11'h000, 11'h000};
        @(posedge aclk);
        timing <= '0;
        repeat (3) @(posedge aclk);
    endtask
    // one raster, sink stalled then drained
    task automatic win(input logic [21:0] base);
        logic [21:0] e;
        aq.delete();
        pq.delete();
        pix_ready <= 1'b0;
        for (int v = 0; v < 4; v++)
            for (int h = 0; h < 16; h++)
            begin
                timing <= '{(h < 12), (h == 0), 1'b0, 1'b0, 11'(h), 11'(v)};
                @(posedge aclk);
            end
        timing <= '0;
        pix_ready <= 1'b1;
        repeat (40) @(posedge aclk);
        chk("fetch count", aq.size(), 8);
        chk("pixel count", pq.size(), 8);
        for (int i = 0; i < 8; i++)
        begin
            e = base + 22'((i / 4) * 1024 + (i % 4));
            chk("fetch addr", aq[i], e);
            chk("pixel", pq[i], e[15:0]);
        end
    endtask
    ////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (rd_valid === 1'b1) aq.push_back(rd_addr);
        if (pix_valid === 1'b1 && pix_ready === 1'b1) pq.push_back(pix_data);
        if (cyc == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cap_frame_done, pix_ready} = '0;
        {awaddr, araddr, wdata} = '0;
        timing = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("idle outputs", {bvalid, rvalid, rd_valid, pix_valid}, 0);
        foreach (rows[i])
        begin
            wr(rows[i][71:64], rows[i][63:32]);
            if (rows[i][71:64] == 8'h34) chk("bresp", lb, 2);
            rd(rows[i][71:64], d, rs);
            chk("rdata", d, rows[i][31:0]);
            chk("rresp", rs, (rows[i][71:64] == 8'h34) ? 2 : 0);
        end
        win(22'h000100);
        wr(8'h08, 32'h100);
        repeat (2)
        begin
            cap_frame_done <= 1'b1;
            @(posedge aclk);
            cap_frame_done <= 1'b0;
            @(posedge aclk);
        end
        vs(1'b0);
        rd(8'h30, d, rs);
        chk("status run", d, 32'h19);
        win(22'h002000);
        wr(8'h20, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h20);
        vs(1'b1);
        rd(8'h30, d, rs);
        chk("status odd", d, 32'h11);
        vs(1'b0);
        rd(8'h30, d, rs);
        chk("status even", d, 32'h12);
        tally_and_finish();
    end
endmodule

// >>> bench/vwd_mem_model.sv
// Purpose: pixel memory behind the fetch port
// Assumes: every request accepted, returns held until taken
// Notes: returns low address half; idle every fourth slot
`timescale 1ns/100ps
module vwd_mem_model (
    input logic aclk,
    input logic aresetn,
    input logic rd_valid,
    input logic [21:0] rd_addr,
    input logic mem_rready,
    output logic mem_rvalid,
    output logic [15:0] mem_rdata
);
    logic [15:0] q[$];
    logic [1:0] gap;
    logic go;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q.delete();
            gap <= 2'h0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 16'h0000;
        end
        else
        begin
            if (rd_valid === 1'b1)
                q.push_back(rd_addr[15:0]);
            if (mem_rvalid && mem_rready)
                void'(q.pop_front());
            go = (q.size() != 0) && (gap != 2'h3);
            // untaken offer holds; idle data scrambled
            if (!(mem_rvalid && !mem_rready))
            begin
                gap <= gap + 2'h1;
                mem_rvalid <= go;
                mem_rdata <= go ? q[0] : ~mem_rdata;
            end
        end
    end
endmodule

// >>> design/vwd_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active low reset
// Notes: head entry drives the output straight from a flop
`timescale 1ns/100ps
module vwd_buf2 #(
    parameter int W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [W-1:0] tail;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_cnt = cnt;
        if (push && !pop)
        begin
            next_cnt = cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 2'h1;
        end
    end

    // registered ready: a stall reaches the source a cycle late
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 2'h0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            out_valid <= (next_cnt != 2'h0);
            in_ready <= (next_cnt != 2'h2);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_data <= '0;
            tail <= '0;
        end
        else
        begin
            if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop)))
            begin
                out_data <= in_data;
            end
            else if (pop && cnt == 2'h2)
            begin
                out_data <= tail;
            end
            if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop)))
            begin
                tail <= in_data;
            end
        end
    end

endmodule

// >>> design/vwd_defs.svh
// Purpose: constants of the video window display block
// Assumes: 32-bit register bus, byte addresses below
// Notes: offsets, field positions, reset values, bus answers and conversion coefficients
//
// Summary of operation
// - with window enabled, show the selected capture area at 16 bits per pixel.
// - while capture is stopped, the displayed area follows the capture area index; while it runs, the last finished area.
// - window size equals the capture window width and height.
// - non-interlace mode accepts any start position.
// - scan mode field picks non-interlace, interlace or interlace sync and video.
// - four capture modes; software pairs each with a fitting display mode.
// - non-interlace capture shows one whole frame per vertical cycle.
// - interlace sync display of non-interlace capture drops one field each frame.
// - sync and video mode may pair even and odd lines in reversed order.
// - display side convert set converts stored luma/chroma to RGB on read.
`ifndef VWD_DEFS_SVH
`define VWD_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define VWD_OFF_DMODE 8'h00
`define VWD_OFF_DMODE2 8'h04
`define VWD_OFF_CMODE 8'h08
`define VWD_OFF_WWIDTH 8'h0C
`define VWD_OFF_WHEIGHT 8'h10
`define VWD_OFF_DWIDTH 8'h14
`define VWD_OFF_DHEIGHT 8'h18
`define VWD_OFF_HSTART 8'h1C
`define VWD_OFF_VSTART 8'h20
`define VWD_OFF_BASE0 8'h24
`define VWD_OFF_BASE1 8'h28
`define VWD_OFF_BASE2 8'h2C
`define VWD_OFF_STATUS 8'h30

////////////////////////////////////////////////////////////////////////////////
// field positions
`define VWD_BIT_ENABLE 0
`define VWD_BIT_CONVERT 1
`define VWD_BIT_RUN 8
`define VWD_POS_AREA 4

////////////////////////////////////////////////////////////////////////////////
// reset values and answers
`define VWD_RST_COORD 11'h000
`define VWD_RST_BASE 22'h000000
`define VWD_RESP_OKAY 2'h0
`define VWD_RESP_SLVERR 2'h2

////////////////////////////////////////////////////////////////////////////////
// conversion coefficients, scaled by 256
`define VWD_K_RCR 20'sh0015F
`define VWD_K_GCR 20'sh000B3
`define VWD_K_GCB 20'sh00009
`define VWD_K_BCB 20'sh001BB
`define VWD_C_OFS 20'sh00080

`endif

// >>> design/vwd_display.sv
// Purpose: video window overlay fetch and colour conversion
// Assumes: timing struct and capture done pulse are on aclk
// Notes: memory read port never stalls; returns may be held back
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "vwd_defs.svh"
module vwd_display
import vwd_pkg::*;
#(
    parameter int LINE_PIX = 1024,
    parameter int ADDR_W = 22
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire vwd_timing_s timing,
    input wire logic cap_frame_done,
    output logic rd_valid,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic mem_rvalid,
    input wire logic [15:0] mem_rdata,
    output logic mem_rready,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [15:0] pix_data
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic vwd_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `VWD_OFF_STATUS);
    endfunction

    function automatic logic [31:0] vwd_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] vwd_sat(input logic signed [19:0] v);
        if (v < 20'sh0)
        begin
            return 8'h00;
        end
        else if (v > 20'sh000FF)
        begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    function automatic logic [15:0] vwd_to_rgb(input logic [7:0] y, input logic [7:0] cb,
                                               input logic [7:0] cr);
        logic signed [19:0] dy;
        logic signed [19:0] dcb;
        logic signed [19:0] dcr;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        dy = $signed({12'h000, y});
        dcb = $signed({12'h000, cb}) - `VWD_C_OFS;
        dcr = $signed({12'h000, cr}) - `VWD_C_OFS;
        r = vwd_sat(dy + ((dcr * `VWD_K_RCR) >>> 8));
        g = vwd_sat(dy - ((dcr * `VWD_K_GCR + dcb * `VWD_K_GCB) >>> 8));
        b = vwd_sat(dy + ((dcb * `VWD_K_BCB) >>> 8));
        return {r[7:3], g[7:2], b[7:3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    vwd_scan_e scan_mode_field;
    vwd_cap_e capture_mode;
    logic video_window_enable;
    logic display_side_convert;
    logic capture_run;
    logic [1:0] capture_area_index;
    logic [10:0] window_width;
    logic [10:0] window_height;
    logic [10:0] display_width;
    logic [10:0] display_height;
    logic [10:0] window_h_start;
    logic [10:0] window_v_start;
    logic [ADDR_W-1:0] capture_area_base [3];
    logic [1:0] show_area;
    logic [1:0] fill_area;
    logic [1:0] done_area;
    logic done_seen;

    ////////////////////////////////////////////////////////////////////////////
    // bus write side

    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic do_wr;
    logic next_aw_hold;
    logic next_w_hold;
    logic [31:0] rd_word;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
    assign next_aw_hold = (aw_hold && !do_wr) || aw_take;
    assign next_w_hold = (w_hold && !do_wr) || w_take;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VWD_RESP_OKAY;
        end
        else
        begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            s_axi_awready <= !next_aw_hold;
            s_axi_wready <= !next_w_hold;
            if (aw_take)
            begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= vwd_mapped(aw_addr) ? `VWD_RESP_OKAY : `VWD_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // status and unmapped words ignore writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scan_mode_field <= VWD_SCAN_NONINT;
            capture_mode <= VWD_CAP_NONINT;
            video_window_enable <= 1'b0;
            display_side_convert <= 1'b0;
            capture_run <= 1'b0;
            capture_area_index <= 2'h0;
            window_width <= `VWD_RST_COORD;
            window_height <= `VWD_RST_COORD;
            display_width <= `VWD_RST_COORD;
            display_height <= `VWD_RST_COORD;
            window_h_start <= `VWD_RST_COORD;
            window_v_start <= `VWD_RST_COORD;
            for (int i = 0; i < 3; i++)
            begin
                capture_area_base[i] <= `VWD_RST_BASE;
            end
        end
        else if (do_wr)
        begin
            unique case (aw_addr)
                `VWD_OFF_DMODE: scan_mode_field <= vwd_scan_e'(w_strb[0] ? w_data[1:0] : scan_mode_field);
                `VWD_OFF_DMODE2:
                begin
                    video_window_enable <= vwd_merge({31'h0, video_window_enable}, w_data, w_strb)[`VWD_BIT_ENABLE];
                    display_side_convert <= vwd_merge({30'h0, display_side_convert, 1'b0}, w_data,
                                                      w_strb)[`VWD_BIT_CONVERT];
                end
                `VWD_OFF_CMODE:
                begin
                    capture_mode <= vwd_cap_e'(w_strb[0] ? w_data[1:0] : capture_mode);
                    capture_area_index <= w_strb[0] ? w_data[`VWD_POS_AREA +: 2] : capture_area_index;
                    capture_run <= w_strb[1] ? w_data[`VWD_BIT_RUN] : capture_run;
                end
                `VWD_OFF_WWIDTH: window_width <= vwd_merge({21'h0, window_width}, w_data, w_strb)[10:0];
                `VWD_OFF_WHEIGHT: window_height <= vwd_merge({21'h0, window_height}, w_data, w_strb)[10:0];
                `VWD_OFF_DWIDTH: display_width <= vwd_merge({21'h0, display_width}, w_data, w_strb)[10:0];
                `VWD_OFF_DHEIGHT: display_height <= vwd_merge({21'h0, display_height}, w_data, w_strb)[10:0];
                `VWD_OFF_HSTART: window_h_start <= vwd_merge({21'h0, window_h_start}, w_data, w_strb)[10:0];
                `VWD_OFF_VSTART: window_v_start <= vwd_merge({21'h0, window_v_start}, w_data, w_strb)[10:0];
                `VWD_OFF_BASE0: capture_area_base[0] <= vwd_merge(32'(capture_area_base[0]), w_data,
                                                                  w_strb)[ADDR_W-1:0];
                `VWD_OFF_BASE1: capture_area_base[1] <= vwd_merge(32'(capture_area_base[1]), w_data,
                                                                  w_strb)[ADDR_W-1:0];
                `VWD_OFF_BASE2: capture_area_base[2] <= vwd_merge(32'(capture_area_base[2]), w_data,
                                                                  w_strb)[ADDR_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus read side

    always_comb
    begin
        rd_word = 32'h00000000;
        unique case (s_axi_araddr)
            `VWD_OFF_DMODE: rd_word = {30'h0, scan_mode_field};
            `VWD_OFF_DMODE2: rd_word = {30'h0, display_side_convert, video_window_enable};
            `VWD_OFF_CMODE: rd_word = {23'h0, capture_run, 2'h0, capture_area_index, 2'h0, capture_mode};
            `VWD_OFF_WWIDTH: rd_word = {21'h0, window_width};
            `VWD_OFF_WHEIGHT: rd_word = {21'h0, window_height};
            `VWD_OFF_DWIDTH: rd_word = {21'h0, display_width};
            `VWD_OFF_DHEIGHT: rd_word = {21'h0, display_height};
            `VWD_OFF_HSTART: rd_word = {21'h0, window_h_start};
            `VWD_OFF_VSTART: rd_word = {21'h0, window_v_start};
            `VWD_OFF_BASE0: rd_word = 32'(capture_area_base[0]);
            `VWD_OFF_BASE1: rd_word = 32'(capture_area_base[1]);
            `VWD_OFF_BASE2: rd_word = 32'(capture_area_base[2]);
            `VWD_OFF_STATUS: rd_word = {26'h0, done_area, fill_area, show_area};
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VWD_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= vwd_mapped(s_axi_araddr) ? `VWD_RESP_OKAY : `VWD_RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_rvalid <= !s_axi_rready;
            s_axi_arready <= s_axi_rready;
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture area rotation and displayed area

    // a frame done with vsync shows next vsync
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fill_area <= 2'h0;
            done_area <= 2'h0;
            done_seen <= 1'b0;
            show_area <= 2'h0;
        end
        else
        begin
            if (capture_run && cap_frame_done)
            begin
                done_area <= fill_area;
                done_seen <= 1'b1;
                fill_area <= (fill_area == 2'h2) ? 2'h0 : fill_area + 2'h1;
            end
            else if (!capture_run)
            begin
                fill_area <= 2'h0;
                done_seen <= 1'b0;
            end
            if (timing.vsync && !(scan_mode_field == VWD_SCAN_INTERLACE && timing.field_odd))
            begin
                if (capture_run && done_seen)
                begin
                    show_area <= done_area;
                end
                else if (!capture_run)
                begin
                    show_area <= (capture_area_index == 2'h3) ? 2'h0 : capture_area_index;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch requests

    logic in_h;
    logic in_v;
    logic [10:0] col;
    logic [10:0] row;

    assign in_h = ({1'b0, timing.h_pos} >= {1'b0, window_h_start})
        && ({1'b0, timing.h_pos} < {1'b0, window_h_start} + {1'b0, window_width});
    // any start is used as given
    assign in_v = ({1'b0, timing.v_pos} >= {1'b0, window_v_start})
        && ({1'b0, timing.v_pos} < {1'b0, window_v_start} + {1'b0, window_height});
    assign col = timing.h_pos - window_h_start;
    assign row = timing.v_pos - window_v_start;

    // no display clipping; software places it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_valid <= 1'b0;
            rd_addr <= '0;
        end
        else
        begin
            // fetch 16-bit pixels of the shown area
            rd_valid <= video_window_enable && timing.de && in_h && in_v;
            rd_addr <= capture_area_base[show_area] + ADDR_W'(row) * ADDR_W'(LINE_PIX) + ADDR_W'(col);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return path, conversion and buffer

    logic ret_odd;
    logic [7:0] held_cb;
    logic [15:0] conv_pix;
    logic buf_ready;
    logic ret_take;

    assign ret_take = mem_rvalid && buf_ready;

    // chroma alternates cb, cr from the left edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ret_odd <= 1'b0;
            held_cb <= 8'h80;
        end
        else if (timing.hsync)
        begin
            ret_odd <= 1'b0;
        end
        else if (ret_take)
        begin
            ret_odd <= !ret_odd;
            if (!ret_odd)
            begin
                held_cb <= mem_rdata[7:0];
            end
        end
    end

    always_comb
    begin
        conv_pix = mem_rdata;
        if (display_side_convert)
        begin
            conv_pix = ret_odd ? vwd_to_rgb(mem_rdata[15:8], held_cb, mem_rdata[7:0])
                               : vwd_to_rgb(mem_rdata[15:8], mem_rdata[7:0], 8'h80);
        end
    end

    assign mem_rready = buf_ready;

    vwd_buf2 #(
        .W(16)
    ) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(mem_rvalid),
        .in_ready(buf_ready),
        .in_data(conv_pix),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_data)
    );

endmodule

// >>> design/vwd_pkg.sv
// Purpose: types of the video window display block
// Assumes: nothing beyond the defs header
// Notes: timing struct comes from the sync generator on aclk
package vwd_pkg;

    typedef enum logic [1:0] {
        VWD_SCAN_NONINT,
        VWD_SCAN_INTERLACE,
        VWD_SCAN_SYNC_VIDEO,
        VWD_SCAN_RESERVED
    } vwd_scan_e;

    typedef enum logic [1:0] {
        VWD_CAP_NONINT,
        VWD_CAP_ODD_ONLY,
        VWD_CAP_FIELD,
        VWD_CAP_FRAME
    } vwd_cap_e;

    typedef struct packed {
        logic de;
        logic hsync;
        logic vsync;
        logic field_odd;
        logic [10:0] h_pos;
        logic [10:0] v_pos;
    } vwd_timing_s;

    typedef logic [21:0] vwd_addr_t;

endpackage
